//--- design/rlfm_monitor.sv
// receive link fault monitor and channel control for two receive channels
`timescale 1ns/100ps
module rlfm_monitor
    import rlfm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          rst_n_i,
    // register port
    input  wire logic [7:0]                    addr_i,
    input  wire logic [31:0]                   wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic [31:0]                        rdata_o,
    // pins from the analog front and recovery loop (asynchronous)
    input  wire logic [NUM_CH-1:0]             amp_primary_ok_i,
    input  wire logic [NUM_CH-1:0]             amp_secondary_ok_i,
    input  wire logic [NUM_CH-1:0]             recovered_bit_i,
    input  wire logic [NUM_CH-1:0]             recovered_char_tick_i,
    input  wire logic [NUM_CH-1:0]             training_tick_i,
    input  wire logic [NUM_CH-1:0]             ref_clock_present_i,
    input  wire logic [NUM_CH*2-1:0]           speed_range_select_i,
    // receive outputs
    output logic [NUM_CH-1:0]                  link_fault_n_o,
    output logic [NUM_CH-1:0]                  line_input_select_o,
    output logic [NUM_CH-1:0]                  rx_channel_power_on_o,
    output logic [NUM_CH-1:0]                  force_training_o,
    output logic [NUM_CH*RLFM_CHAR_BITS-1:0]   rx_data_o,
    output logic [NUM_CH-1:0]                  selftest_status_o,
    // reclocker drivers
    output logic [NUM_CH*2-1:0]                reclk_oe_o,
    output logic [NUM_CH-1:0]                  reclk_logic_on_o,
    output logic [NUM_CH-1:0]                  reclk_serial_o
);
    localparam int TC_W = 7;
    localparam logic [TC_W-1:0] NO_TRANS_LIM = TC_W'(RLFM_NO_TRANS_BITS);
    localparam logic [RLFM_RC_CNT_W-1:0] RC_LAST = RLFM_RC_CNT_W'(RLFM_RC_PERIOD_CHARS - 1);
    // ppm tolerance in training ticks per interval, at full-rate training
    localparam logic [RLFM_RC_CNT_W-1:0] PPM_TOL =
        RLFM_RC_CNT_W'((RLFM_RC_PERIOD_CHARS * RLFM_PPM_LIMIT) / RLFM_PPM_SCALE);

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction : rise

    function automatic logic [RLFM_RC_CNT_W-1:0] absdiff(input logic [RLFM_RC_CNT_W-1:0] a,
                                                         input logic [RLFM_RC_CNT_W-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    // synchronisers, stage 2 and a history stage for edge detection
    localparam int SW = 7;
    logic [SW-1:0] sync1_reg [NUM_CH];
    logic [SW-1:0] sync2_reg [NUM_CH];
    logic [SW-1:0] hist_reg  [NUM_CH];
    logic [1:0]    spd1_reg  [NUM_CH];
    logic [1:0]    spd2_reg  [NUM_CH];

    // configuration, shared threshold
    logic [1:0]           thr_reg, thr_next;
    rlfm_chan_cfg_t       cfg_reg  [NUM_CH];
    rlfm_chan_cfg_t       cfg_next [NUM_CH];
    logic [31:0]          rdata_next;

    // per channel state
    logic [TC_W-1:0]          tc_reg   [NUM_CH], tc_next   [NUM_CH];
    logic [RLFM_RC_CNT_W-1:0] rcc_reg  [NUM_CH], rcc_next  [NUM_CH];
    logic [RLFM_RC_CNT_W-1:0] trc_reg  [NUM_CH], trc_next  [NUM_CH];
    logic                     frc_reg  [NUM_CH], frc_next  [NUM_CH];
    logic [RLFM_CHAR_BITS-1:0] sh_reg  [NUM_CH], sh_next   [NUM_CH];
    logic                     lon_reg  [NUM_CH], lon_next  [NUM_CH];
    logic                     sts_reg  [NUM_CH], sts_next  [NUM_CH];
    logic [RLFM_CHAR_BITS-1:0] dat_reg [NUM_CH], dat_next  [NUM_CH];
    logic [RLFM_CHAR_BITS-1:0] rk_reg  [NUM_CH], rk_next   [NUM_CH];
    logic [3:0]               rkb_reg  [NUM_CH], rkb_next  [NUM_CH];
    logic                     rks_reg  [NUM_CH], rks_next  [NUM_CH];
    logic                     lf_reg   [NUM_CH], lf_next   [NUM_CH];
    rlfm_chan_stat_t          st_reg   [NUM_CH], st_next   [NUM_CH];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                sync1_reg[c] <= '0;
                sync2_reg[c] <= '0;
                hist_reg[c]  <= '0;
                spd1_reg[c]  <= 2'h0;
                spd2_reg[c]  <= 2'h0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                sync1_reg[c] <= {ref_clock_present_i[c], training_tick_i[c],
                                 recovered_char_tick_i[c], recovered_bit_i[c],
                                 amp_secondary_ok_i[c], amp_primary_ok_i[c], 1'b0};
                sync2_reg[c] <= sync1_reg[c];
                hist_reg[c]  <= sync2_reg[c];
                spd1_reg[c]  <= speed_range_select_i[c*2 +: 2];
                spd2_reg[c]  <= spd1_reg[c];
            end
        end
    end

    // register file and bus
    always_comb begin
        thr_next   = thr_reg;
        rdata_next = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            cfg_next[c] = cfg_reg[c];
            if (wr_i && addr_i == RLFM_OFF_ADDR_CTRL) begin
                cfg_next[c] = rlfm_chan_cfg_t'(wdata_i[c*8 +: 7]);
            end
        end
        if (wr_i && addr_i == RLFM_OFF_ADDR_CTRL) begin
            thr_next = wdata_i[31:30];
        end
        if (rd_i) begin
            case (addr_i)
                RLFM_OFF_ADDR_CTRL: begin
                    rdata_next[31:30] = thr_reg;
                    for (int c = 0; c < NUM_CH; c++) begin
                        rdata_next[c*8 +: 7] = cfg_reg[c];
                    end
                end
                RLFM_OFF_ADDR_STAT: begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        rdata_next[c*8 +: 5] = st_reg[c];
                    end
                end
                default: rdata_next = '0;
            endcase
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            logic       pw, amp_ok, bit_edge, ct, tt, amp_sel, nt, ok;
            logic [RLFM_RC_CNT_W-1:0] trc_exp, tol;
            rlfm_speed_t spd;
            pw       = cfg_reg[c].power_on;
            amp_sel  = cfg_reg[c].line_sel ? sync2_reg[c][2] : sync2_reg[c][1];
            amp_ok   = (thr_reg == RLFM_THR_OFF) | amp_sel;
            bit_edge = sync2_reg[c][3] ^ hist_reg[c][3];
            ct       = rise(sync2_reg[c][4], hist_reg[c][4]);
            tt       = rise(sync2_reg[c][5], hist_reg[c][5]);
            case (spd2_reg[c])
                2'h0:    spd = RLFM_SPD_LOW;
                2'h1:    spd = RLFM_SPD_MID;
                2'h3:    spd = RLFM_SPD_HIGH;
                default: spd = RLFM_SPD_BAD;
            endcase
            // half-rate training sees half the ticks per interval
            trc_exp = cfg_reg[c].trg_half ? RLFM_RC_CNT_W'(RLFM_RC_PERIOD_CHARS / 2)
                                          : RLFM_RC_CNT_W'(RLFM_RC_PERIOD_CHARS);
            tol     = cfg_reg[c].trg_half ? (PPM_TOL >> 1) : PPM_TOL;
            tc_next[c]  = tc_reg[c];
            rcc_next[c] = rcc_reg[c];
            trc_next[c] = trc_reg[c];
            frc_next[c] = frc_reg[c];
            if (!pw) begin
                tc_next[c]  = '0;
                rcc_next[c] = '0;
                trc_next[c] = '0;
                frc_next[c] = 1'b0;
            end else begin
                if (bit_edge) begin
                    tc_next[c] = '0;
                end else if (ct && tc_reg[c] <= NO_TRANS_LIM) begin
                    // counts in characters scaled to bits
                    tc_next[c] = tc_reg[c] + TC_W'(RLFM_CHAR_BITS);
                end
                if (tt) begin
                    trc_next[c] = trc_reg[c] + 1'b1;
                end
                if (ct) begin
                    rcc_next[c] = rcc_reg[c] + 1'b1;
                    if (rcc_reg[c] == RC_LAST) begin
                        rcc_next[c] = '0;
                        trc_next[c] = '0;
                        // off by more than the ppm window: force, else release
                        frc_next[c] = absdiff(trc_reg[c], trc_exp) > tol;
                    end
                end
            end
            nt = tc_reg[c] > NO_TRANS_LIM;
            // both drivers off powers down the reclocker only
            ok = pw & amp_ok & ~nt & ~frc_reg[c] & sync2_reg[c][6]
                 & (spd != RLFM_SPD_BAD);
            lf_next[c] = ok;
            st_next[c] = '{link_ok: ok, rc_forcing: frc_reg[c], no_trans: nt,
                           amp_bad: ~amp_ok,
                           reserved_mode: (spd == RLFM_SPD_LOW) & cfg_reg[c].trg_half};
            // taken from next values so these outputs leave flip-flops in step with the rest
            sts_next[c] = (cfg_next[c].selftest_mode == RLFM_BIST_STATUS_ON) & ok;
            lon_next[c] = |cfg_next[c].reclk_oe;
            // deserialise, then retime character into reclocker register
            sh_next[c]  = sh_reg[c];
            dat_next[c] = dat_reg[c];
            rk_next[c]  = rk_reg[c];
            rkb_next[c] = rkb_reg[c];
            rks_next[c] = rks_reg[c];
            if (pw && bit_edge) begin
                sh_next[c] = {sh_reg[c][RLFM_CHAR_BITS-2:0], sync2_reg[c][3]};
            end
            if (pw && ct) begin
                dat_next[c] = sh_reg[c];
                if (|cfg_reg[c].reclk_oe) begin
                    rk_next[c]  = sh_reg[c];
                    rkb_next[c] = '0;
                end
            end else if (|cfg_reg[c].reclk_oe && rkb_reg[c] < 4'(RLFM_CHAR_BITS)) begin
                rks_next[c] = rk_reg[c][RLFM_CHAR_BITS-1 - rkb_reg[c]];
                rkb_next[c] = rkb_reg[c] + 1'b1;
            end
            if (~|cfg_reg[c].reclk_oe) begin
                rks_next[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_reg <= RLFM_THR_OFF;
            rdata_o <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_reg[c] <= '0;
                tc_reg[c]  <= '0;
                rcc_reg[c] <= '0;
                trc_reg[c] <= '0;
                frc_reg[c] <= 1'b0;
                sh_reg[c]  <= '0;
                lon_reg[c] <= 1'b0;
                sts_reg[c] <= 1'b0;
                dat_reg[c] <= '0;
                rk_reg[c]  <= '0;
                rkb_reg[c] <= '0;
                rks_reg[c] <= 1'b0;
                lf_reg[c]  <= 1'b0;
                st_reg[c]  <= '0;
            end
        end else begin
            thr_reg <= thr_next;
            rdata_o <= rdata_next;
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_reg[c] <= cfg_next[c];
                tc_reg[c]  <= tc_next[c];
                rcc_reg[c] <= rcc_next[c];
                trc_reg[c] <= trc_next[c];
                frc_reg[c] <= frc_next[c];
                sh_reg[c]  <= sh_next[c];
                lon_reg[c] <= lon_next[c];
                sts_reg[c] <= sts_next[c];
                dat_reg[c] <= dat_next[c];
                rk_reg[c]  <= rk_next[c];
                rkb_reg[c] <= rkb_next[c];
                rks_reg[c] <= rks_next[c];
                lf_reg[c]  <= lf_next[c];
                st_reg[c]  <= st_next[c];
            end
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            link_fault_n_o[c]        = lf_reg[c];
            line_input_select_o[c]   = cfg_reg[c].line_sel;
            rx_channel_power_on_o[c] = cfg_reg[c].power_on;
            force_training_o[c]      = frc_reg[c];
            rx_data_o[c*RLFM_CHAR_BITS +: RLFM_CHAR_BITS] = dat_reg[c];
            selftest_status_o[c]     = sts_reg[c];
            reclk_oe_o[c*2 +: 2]     = cfg_reg[c].reclk_oe;
            reclk_logic_on_o[c]      = lon_reg[c];
            reclk_serial_o[c]        = rks_reg[c];
        end
    end
endmodule : rlfm_monitor

//--- design/rlfm_pkg.sv
// package: constants and carriers for the receive link fault monitor
package rlfm_pkg;
    localparam int          RLFM_CHAR_BITS       = 10;
    localparam int          RLFM_NO_TRANS_CHARS  = 6;
    localparam int          RLFM_NO_TRANS_BITS   = RLFM_NO_TRANS_CHARS * RLFM_CHAR_BITS;
    localparam int          RLFM_RC_PERIOD_CHARS = 4096;
    localparam int          RLFM_PPM_LIMIT       = 1500;
    localparam int          RLFM_PPM_SCALE       = 1000000;
    localparam int          RLFM_RC_CNT_W        = 13;
    localparam logic [1:0]  RLFM_THR_OFF         = 2'h0;
    localparam logic [1:0]  RLFM_THR_LOW         = 2'h1;
    localparam logic [1:0]  RLFM_THR_MID         = 2'h2;
    localparam logic [1:0]  RLFM_THR_HIGH        = 2'h3;
    localparam logic [1:0]  RLFM_BIST_STATUS_ON  = 2'h2;
    localparam logic        RLFM_TRG_HALF        = 1'h1;
    localparam logic [7:0]  RLFM_OFF_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  RLFM_OFF_ADDR_STAT   = 8'h04;

    typedef enum logic [1:0] {
        RLFM_SPD_LOW,
        RLFM_SPD_MID,
        RLFM_SPD_HIGH,
        RLFM_SPD_BAD
    } rlfm_speed_t;

    // per channel configuration
    typedef struct packed {
        logic       power_on;
        logic       line_sel;
        logic       trg_half;
        logic [1:0] selftest_mode;
        logic [1:0] reclk_oe;
    } rlfm_chan_cfg_t;

    // per channel status word
    typedef struct packed {
        logic       link_ok;
        logic       rc_forcing;
        logic       no_trans;
        logic       amp_bad;
        logic       reserved_mode;
    } rlfm_chan_stat_t;
endpackage : rlfm_pkg

//--- verif/rlfm_far_end.sv
// far end model: remote transmitter stream and training clock source
`timescale 1ns/100ps
module rlfm_far_end #(
    parameter int NUM_CH = 2
) (
    // clock
    input  wire logic              mclk_i,
    // knobs from the bench
    input  wire logic [NUM_CH-1:0] trans_en_i,
    input  wire logic [NUM_CH-1:0] half_i,
    input  wire logic [NUM_CH-1:0] slow_i,
    // stream towards the receiver
    output logic [NUM_CH-1:0]      bit_o,
    output logic [NUM_CH-1:0]      char_tick_o,
    output logic [NUM_CH-1:0]      training_tick_o
);
    logic [2:0]        char_cnt = 3'h0;
    logic [2:0]        five_cnt = 3'h0;
    logic [NUM_CH-1:0] bit_reg  = '0;
    // four cycles a character keeps every edge visible through the synchroniser
    always @(posedge mclk_i) begin
        char_cnt <= char_cnt + 3'h1;
        five_cnt <= (five_cnt == 3'h4) ? 3'h0 : five_cnt + 3'h1;
        if (char_cnt[1:0] == 2'h3) begin
            bit_reg <= bit_reg ^ trans_en_i;
        end
    end
    // off-rate training and stopped transitions are the only faults made, and only on command
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            char_tick_o[c]     = char_cnt[1];
            training_tick_o[c] = slow_i[c] ? (five_cnt < 3'h2) :
                                 (half_i[c] ? char_cnt[2] : char_cnt[1]);
        end
    end
    assign bit_o = bit_reg;
endmodule : rlfm_far_end

//--- verif/rlfm_monitor_chk.sv
// checker: port level properties of the receive link fault monitor
`timescale 1ns/100ps
module rlfm_monitor_chk
    import rlfm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input wire logic                mclk_i,
    input wire logic                rst_n_i,
    // register port
    input wire logic [7:0]          addr_i,
    input wire logic [31:0]         wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [31:0]         rdata_o,
    // receive and reclocker outputs
    input wire logic [NUM_CH-1:0]   link_fault_n_o,
    input wire logic [NUM_CH-1:0]   line_input_select_o,
    input wire logic [NUM_CH-1:0]   rx_channel_power_on_o,
    input wire logic [NUM_CH-1:0]   force_training_o,
    input wire logic [NUM_CH-1:0]   selftest_status_o,
    input wire logic [NUM_CH*2-1:0] reclk_oe_o,
    input wire logic [NUM_CH-1:0]   reclk_logic_on_o,
    input wire logic [NUM_CH-1:0]   reclk_serial_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ctrl_wr;
        wr_i && addr_i == RLFM_OFF_ADDR_CTRL;
    endsequence
    sequence s_bad_rd;
        rd_i && addr_i != RLFM_OFF_ADDR_CTRL && addr_i != RLFM_OFF_ADDR_STAT;
    endsequence
    a_cfg_write_lands : assert property (s_ctrl_wr |=>
        rx_channel_power_on_o == {$past(wdata_i[14]), $past(wdata_i[6])} &&
        line_input_select_o == {$past(wdata_i[13]), $past(wdata_i[5])} &&
        reclk_oe_o == {$past(wdata_i[9:8]), $past(wdata_i[1:0])})
        else $error("control write did not reach the outputs");
    a_bad_write_ignored : assert property (wr_i && addr_i != RLFM_OFF_ADDR_CTRL |=>
        $stable(rx_channel_power_on_o) && $stable(reclk_oe_o))
        else $error("write to a foreign address changed the setup");
    a_bad_read_zero : assert property (s_bad_rd |=> rdata_o == 32'h0)
        else $error("unmapped read returned data");
    a_rdata_idle : assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside the answer cycle");
    a_off_means_fault : assert property (
        (~rx_channel_power_on_o & ~$past(rx_channel_power_on_o) & link_fault_n_o) == '0)
        else $error("disabled channel shows a good link");
    a_force_means_fault : assert property (
        (force_training_o & $past(force_training_o) & link_fault_n_o) == '0)
        else $error("good link shown while oscillator forced");
    a_logic_on_or : assert property ($stable(reclk_oe_o) |->
        reclk_logic_on_o == {|reclk_oe_o[3:2], |reclk_oe_o[1:0]})
        else $error("reclocker logic state differs from its drivers");
    a_serial_quiet : assert property ((reclk_oe_o[1:0] == 2'h0) [*2] |->
        reclk_serial_o[0] == 1'b0)
        else $error("serial output moves with both drivers off");
    a_selftest_gate : assert property (!link_fault_n_o[0] [*3] |->
        !selftest_status_o[0])
        else $error("self-test status without a good link");
endmodule : rlfm_monitor_chk

bind rlfm_monitor rlfm_monitor_chk #(.NUM_CH(NUM_CH)) rlfm_monitor_chk_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .link_fault_n_o(link_fault_n_o),
    .line_input_select_o(line_input_select_o), .rx_channel_power_on_o(rx_channel_power_on_o),
    .force_training_o(force_training_o), .selftest_status_o(selftest_status_o),
    .reclk_oe_o(reclk_oe_o), .reclk_logic_on_o(reclk_logic_on_o),
    .reclk_serial_o(reclk_serial_o)
);

//--- verif/testbench.sv
// testbench: drives the link fault monitor beside a far end model
`timescale 1ns/100ps
module testbench;
    import rlfm_pkg::*;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, r, q, seed = 32'h5b233e40;
    logic [1:0]  amp_p = 2'h3, amp_s = 2'h3, ref_ok = 2'h3, trans_en = 2'h3, slow = 2'h0;
    logic [1:0]  lfn, lsel, pwr, frc, sts, rlon, rser, bits, ctk, ttk, hi, lo;
    logic [3:0]  spd = 4'hf, oe;
    logic [19:0] rxd;
    int          errors = 0, checks_done = 0, n, i;
    rlfm_monitor #(.NUM_CH(2)) rlfm_monitor_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .amp_primary_ok_i(amp_p), .amp_secondary_ok_i(amp_s),
        .recovered_bit_i(bits), .recovered_char_tick_i(ctk), .training_tick_i(ttk),
        .ref_clock_present_i(ref_ok), .speed_range_select_i(spd), .link_fault_n_o(lfn),
        .line_input_select_o(lsel), .rx_channel_power_on_o(pwr), .force_training_o(frc),
        .rx_data_o(rxd), .selftest_status_o(sts), .reclk_oe_o(oe), .reclk_logic_on_o(rlon),
        .reclk_serial_o(rser));
    // channel 1 always trains at half rate
    rlfm_far_end #(.NUM_CH(2)) rlfm_far_end_inst (
        .mclk_i(mclk_i), .trans_en_i(trans_en), .half_i(2'h2), .slow_i(slow),
        .bit_o(bits), .char_tick_o(ctk), .training_tick_o(ttk));
    always #5 mclk_i = ~mclk_i;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function logic [9:0] exp_cfg(input logic [31:0] d);
        return {d[14], d[6], d[13], d[5], d[9:8], d[1:0], |d[9:8], |d[1:0]};
    endfunction : exp_cfg
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task cfg(input logic [1:0] thr, input logic [7:0] b0);
        wr(RLFM_OFF_ADDR_CTRL, {thr, 14'h0, 8'h77, b0});
    endtask : cfg
    // a re-enabled channel shows a good link only after a few cycles through the synchronisers, hence the bounded wait
    task wait_ok;
        for (n = 0; n < 17000 && lfn !== 2'h3; n++) @(posedge mclk_i);
        #1 check(lfn, 2'h3);
    endtask : wait_ok
    task fcase(input int k, input logic [1:0] e);
        @(posedge mclk_i);
        case (k)
            0: amp_p <= 2'h0;
            1: ref_ok[0] <= 1'b0;
            2: spd <= 4'h2;
            3: trans_en[1] <= 1'b0;
            4: cfg(2'h1, 8'h09);
            default: cfg(2'h1, 8'h48);
        endcase
        repeat (100) @(posedge mclk_i);
        for (n = 0; n < 20; n++) begin
            @(posedge mclk_i);
            #1 check(lfn, e);
        end
        if (k == 5) check({rser[0], rlon[0]}, 2'h0);
        if (k == 2) rd(RLFM_OFF_ADDR_STAT, q);
        if (k == 2) check(q[12:8], 5'h11);
        @(posedge mclk_i);
        {amp_p, ref_ok, spd, trans_en} <= 10'h3ff;
        cfg(2'h1, 8'h49);
        wait_ok;
    endtask : fcase
    initial begin
        repeat (16) @(posedge mclk_i);
        #1 check({lfn, oe, pwr, frc, rser, rlon}, 32'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i++) begin
            r = (xs() | 32'h1000) & 32'hffffffef;
            wr(RLFM_OFF_ADDR_CTRL, r);
            wr(8'h08, ~r);
            rd(8'h0c, q);
            check(q, 32'h0);
            check({pwr, lsel, oe, rlon}, exp_cfg(r));
        end
        cfg(2'h1, 8'h49);
        wait_ok;
        check(sts, 2'h1);
        rd(RLFM_OFF_ADDR_STAT, q);
        check({q[12:8], q[4:0]}, 10'h210);
        trans_en[0] <= 1'b0;
        repeat (16) @(posedge mclk_i);
        trans_en[0] <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk_i);
            #1 check(lfn, 2'h3);
        end
        for (i = 0; i < 6; i++) fcase(i, (i == 3) ? 2'h1 : (i == 5) ? 2'h3 : 2'h2);
        @(posedge mclk_i);
        amp_p[0] <= 1'b0;
        cfg(2'h1, 8'h69);
        wait_ok;
        @(posedge mclk_i);
        amp_s[1] <= 1'b0;
        for (i = 3; i >= 0; i--) begin
            cfg(i[1:0], 8'h49);
            repeat (60) @(posedge mclk_i);
            #1 check(lfn, (i == 0) ? 2'h3 : 2'h0);
        end
        @(posedge mclk_i);
        {amp_p, amp_s} <= 4'hf;
        slow[0] <= 1'b1;
        for (n = 0; n < 17000 && frc[0] !== 1'b1; n++) @(posedge mclk_i);
        slow[0] <= 1'b0;
        #1 check({frc, lfn[0]}, 3'h2);
        for (n = 0; n < 17000 && frc[0] === 1'b1; n++) @(posedge mclk_i);
        check(n > 16370 && n < 16400, 1);
        wait_ok;
        // reclocked output is only trusted long after the drivers came back on
        {hi, lo} = 4'h0;
        repeat (16) begin
            @(posedge mclk_i);
            #1 {hi, lo} = {hi | rser, lo | ~rser};
        end
        check({hi, lo}, 4'hf);
        check({rxd[19:11] ^ rxd[18:10], rxd[9:1] ^ rxd[8:0]}, 18'h3ffff);
        print_verdict;
    end
    initial begin
        repeat (100000) @(posedge mclk_i);
        errors++;
        print_verdict;
    end
endmodule : testbench
